// >>> logic/ddl_top.sv
// Digital delay-locked loop, modelled in the sampled system clock domain.
// Assumes the input and feedback clocks are far slower than CLK_I and
// that freeze and latch controls come from logic on CLK_I.
`timescale 1ns/10ps
module ddl_top #(
   parameter int TAPS = ddl_pkg::DEF_TAPS
) (
   input  wire logic                          CLK_I,
   input  wire logic                          RSTN_I,
   input  wire logic                          INPUT_CLOCK_I,
   input  wire logic                          FEEDBACK_CLOCK_IN_I,
   input  wire ddl_pkg::ddl_mode_t            MODE_I,
   input  wire ddl_pkg::ddl_ref_t             REF_SEL_I,
   input  wire ddl_pkg::ddl_fb_t              FB_SEL_I,
   input  wire ddl_pkg::ddl_pri_cfg_t         PRIMARY_CFG_I,
   input  wire ddl_pkg::ddl_sec_cfg_t         SECONDARY_CFG_I,
   input  wire logic                          CODE_FREEZE_I,
   input  wire logic                          CODE_UPDATE_LATCH_I,
   output logic                               PRIMARY_CLOCK_OUT_O,
   output logic                               SECONDARY_CLOCK_OUT_O,
   output logic [ddl_pkg::TAP_W-1:0]          DELAY_CODE_BUS_O,
   output logic [ddl_pkg::TAP_W-1:0]          HELD_CODE_O,
   output logic signed [ddl_pkg::ERR_W-1:0]   PHASE_ERROR_O,
   output logic                               LOCK_O
);

   localparam int TW = ddl_pkg::TAP_W;
   localparam int CW = ddl_pkg::CNT_W;
   localparam int EW = ddl_pkg::ERR_W;
   localparam logic [TW-1:0] TAP_MAX = TW'(TAPS - 1);
   localparam logic [CW-1:0] CNT_MAX = '1;
   localparam logic signed [EW-1:0] TOL_P = EW'(ddl_pkg::LOCK_TOL);
   localparam logic signed [EW-1:0] TOL_N = -TOL_P;
   localparam logic [2:0] RUNS_LAST = 3'(ddl_pkg::LOCK_RUNS - 1);

   // Refuse chain lengths the code width cannot address
   generate
      if (TAPS < 8 || TAPS > (1 << TW)) begin : g_bad_taps
         $error("TAPS out of range for delay code width");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers; stage 0 feeds only stage 1
   logic [1:0] in_sync;
   logic [1:0] fb_sync;

   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         in_sync <= 2'h0;
         fb_sync <= 2'h0;
      end else begin
         in_sync <= {in_sync[0], INPUT_CLOCK_I};
         fb_sync <= {fb_sync[0], FEEDBACK_CLOCK_IN_I};
      end
   end

   wire in_lvl = in_sync[1];
   wire fb_pin = fb_sync[1];

   ////////////////////////////////////////////////////////////////////
   // Delay chain, one system cycle per tap, plus input divider
   logic [TAPS-1:0] chain;
   logic            in_prev;
   logic            in_div;
   logic [TW-1:0]   code;

   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         chain   <= '0;
         in_prev <= 1'b0;
         in_div  <= 1'b0;
      end else begin
         chain   <= {chain[TAPS-2:0], in_lvl};
         in_prev <= in_lvl;
         if (in_lvl & ~in_prev)
            in_div <= ~in_div;
      end
   end

   wire code_tap = chain[code];       // Tap steered by the loop

   ////////////////////////////////////////////////////////////////////
   // Source selection; presets override the explicit selects
   wire ddl_pkg::ddl_ref_t eff_ref =
      (MODE_I == ddl_pkg::MODE_CUSTOM) ? REF_SEL_I
                                       : ddl_pkg::REF_INPUT;
   wire ddl_pkg::ddl_fb_t eff_fb =
      (MODE_I == ddl_pkg::MODE_TIMEREF) ? ddl_pkg::FB_TAP :
      (MODE_I == ddl_pkg::MODE_INJECT)  ? ddl_pkg::FB_PIN :
                                          FB_SEL_I;

   wire ref_lvl =
      (eff_ref == ddl_pkg::REF_INPUT) ? in_lvl   :
      (eff_ref == ddl_pkg::REF_INDIV) ? in_div   :
      (eff_ref == ddl_pkg::REF_TAP)   ? code_tap : fb_pin;
   wire fb_lvl =
      (eff_fb == ddl_pkg::FB_PIN)   ? fb_pin :
      (eff_fb == ddl_pkg::FB_INPUT) ? in_lvl :
      (eff_fb == ddl_pkg::FB_TAP)   ? code_tap : fb_pin;

   ////////////////////////////////////////////////////////////////////
   // Phase/frequency detector: cycles from reference to feedback edge
   logic                 ref_prev;
   logic                 fb_prev;
   logic [CW-1:0]        lag;
   logic [CW-1:0]        per;
   logic                 fb_seen;
   logic                 pd_valid;
   logic signed [EW-1:0] err;

   wire ref_rise = ref_lvl & ~ref_prev;
   wire fb_rise  = fb_lvl & ~fb_prev;
   wire [CW-1:0] since = (lag == CNT_MAX) ? CNT_MAX : lag + 1'b1;
   // Fold late edges past half a period into an early (negative) error
   wire wrap = (per != '0) && (since > (per >> 1));
   wire signed [EW-1:0] next_err =
      $signed({1'b0, since}) - (wrap ? $signed({1'b0, per})
                                      : $signed(EW'(0)));
   wire signed [EW-1:0] half_err = $signed({1'b0, per >> 1});

   // Missed feedback edge counts as a frequency error
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         ref_prev <= 1'b0;
         fb_prev  <= 1'b0;
         lag      <= '0;
         per      <= '0;
         fb_seen  <= 1'b0;
         pd_valid <= 1'b0;
         err      <= '0;
      end else begin
         ref_prev <= ref_lvl;
         fb_prev  <= fb_lvl;
         pd_valid <= 1'b0;
         if (ref_rise) begin
            lag     <= '0;
            per     <= since;
            fb_seen <= fb_rise;
            if (fb_rise) begin
               err      <= '0;
               pd_valid <= 1'b1;
            end else if (!fb_seen && per != '0) begin
               err      <= half_err;
               pd_valid <= 1'b1;
            end
         end else begin
            lag <= since;
            if (fb_rise && !fb_seen) begin
               err      <= next_err;
               pd_valid <= 1'b1;
               fb_seen  <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Arithmetic unit: one tap step per comparison, clamped to chain
   wire too_late  = pd_valid && (err > TOL_P);
   wire too_early = pd_valid && (err < TOL_N);
   wire in_win    = pd_valid && !too_late && !too_early;
   wire [TW-1:0] next_code =
      (too_late  && code != '0)      ? code - 1'b1 :
      (too_early && code != TAP_MAX) ? code + 1'b1 : code;

   always_ff @(posedge CLK_I) begin
      if (!RSTN_I)
         code <= ddl_pkg::CODE_RST;
      else if (!CODE_FREEZE_I)
         code <= next_code;
   end

   ////////////////////////////////////////////////////////////////////
   // Code bus to the slave element and its holding register
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         DELAY_CODE_BUS_O <= ddl_pkg::CODE_RST;
         HELD_CODE_O      <= ddl_pkg::CODE_RST;
         PHASE_ERROR_O    <= '0;
      end else begin
         DELAY_CODE_BUS_O <= code;
         PHASE_ERROR_O    <= err;
         if (CODE_UPDATE_LATCH_I)
            HELD_CODE_O <= DELAY_CODE_BUS_O;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Lock tracking; four in-window comparisons set lock, one outside the window drops it
   logic [2:0] runs;

   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         runs   <= 3'h0;
         LOCK_O <= 1'b0;
      end else if (pd_valid) begin
         if (in_win) begin
            if (runs != RUNS_LAST)
               runs <= runs + 1'b1;
            else
               LOCK_O <= 1'b1;
         end else begin
            runs   <= 3'h0;
            LOCK_O <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Primary output tap selection with bypass
   wire pri_raw = PRIMARY_CFG_I.bypass ? in_lvl
                                       : chain[PRIMARY_CFG_I.tap];

   ////////////////////////////////////////////////////////////////////
   // Secondary output: tap plus fine offset, clamped to the chain end
   wire [CW-1:0] fine_off =
      (SECONDARY_CFG_I.fine == ddl_pkg::FINE_45) ?
         per >> ddl_pkg::FINE_SH_45 :
      (SECONDARY_CFG_I.fine == ddl_pkg::FINE_22) ?
         per >> ddl_pkg::FINE_SH_22 :
      (SECONDARY_CFG_I.fine == ddl_pkg::FINE_11) ?
         per >> ddl_pkg::FINE_SH_11 : '0;
   wire [CW:0] sec_sum = {1'b0, fine_off} +
                         (CW+1)'(SECONDARY_CFG_I.tap);
   wire [TW-1:0] sec_idx = (sec_sum > (CW+1)'(TAP_MAX)) ? TAP_MAX
                                                        : sec_sum[TW-1:0];
   wire sec_base = SECONDARY_CFG_I.bypass ? in_lvl
                                          : chain[sec_idx];

   // Divider counts rising edges of the selected secondary signal
   logic       sec_prev;
   logic [1:0] sec_cnt;

   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         sec_prev <= 1'b0;
         sec_cnt  <= 2'h0;
      end else begin
         sec_prev <= sec_base;
         if (sec_base & ~sec_prev)
            sec_cnt <= sec_cnt + 1'b1;
      end
   end

   wire sec_raw =
      (SECONDARY_CFG_I.div == ddl_pkg::DIV_2) ? sec_cnt[0] :
      (SECONDARY_CFG_I.div == ddl_pkg::DIV_4) ? sec_cnt[1] :
                                                sec_base;

   ////////////////////////////////////////////////////////////////////
   // Duty correction, half period scaled by the divider ratio
   wire [CW-1:0] half_pri = per >> 1;
   wire [CW-1:0] half_sec =
      (SECONDARY_CFG_I.div == ddl_pkg::DIV_2) ? per :
      (SECONDARY_CFG_I.div == ddl_pkg::DIV_4) ?
         ((per > (CNT_MAX >> 1)) ? CNT_MAX : per << 1) : per >> 1;
   logic pri_dcc;
   logic sec_dcc;

   ddl_duty_fix #(.CNT_W(CW)) u_pri_dcc (
      .clk_i  (CLK_I),
      .rstn_i (RSTN_I),
      .sig_i  (pri_raw),
      .half_i (half_pri),
      .dcc_o  (pri_dcc)
   );

   ddl_duty_fix #(.CNT_W(CW)) u_sec_dcc (
      .clk_i  (CLK_I),
      .rstn_i (RSTN_I),
      .sig_i  (sec_raw),
      .half_i (half_sec),
      .dcc_o  (sec_dcc)
   );

   // Final output flops; corrected path lags the raw one by a cycle
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         PRIMARY_CLOCK_OUT_O   <= 1'b0;
         SECONDARY_CLOCK_OUT_O <= 1'b0;
      end else begin
         PRIMARY_CLOCK_OUT_O   <= PRIMARY_CFG_I.dcc_en ? pri_dcc
                                                       : pri_raw;
         SECONDARY_CLOCK_OUT_O <= SECONDARY_CFG_I.dcc_en ? sec_dcc
                                                         : sec_raw;
      end
   end

endmodule

// >>> logic/ddl_pkg.sv
// Shared constants, enumerations and configuration structs for the
// digital delay-locked loop. Assumes a single 20 MHz system clock.
package ddl_pkg;

   // System clock rate
   localparam int CLK_HZ     = 20_000_000;
   // Delay chain length and width of the delay code
   localparam int DEF_TAPS   = 32;
   localparam int TAP_W      = 5;
   // Width of the period and phase counters
   localparam int CNT_W      = 8;
   localparam int ERR_W      = CNT_W + 1;
   // Lock window (cycles) and in-window comparisons needed to lock
   localparam int LOCK_TOL   = 1;
   localparam int LOCK_RUNS  = 4;
   // Reset values
   localparam logic [TAP_W-1:0] CODE_RST = 5'h10;
   // Fine shift as right shifts of the period: 45, 22.5, 11.25 deg
   localparam int FINE_SH_45 = 3;
   localparam int FINE_SH_22 = 4;
   localparam int FINE_SH_11 = 5;

   // Loop presets; custom takes the explicit source selects
   typedef enum logic [1:0] {
      MODE_CUSTOM  = 2'b00,
      MODE_TIMEREF = 2'b01,
      MODE_INJECT  = 2'b10
   } ddl_mode_t;

   // Reference source of the phase detector
   typedef enum logic [1:0] {
      REF_INPUT    = 2'b00,
      REF_INDIV    = 2'b01,
      REF_TAP      = 2'b10,
      REF_FEEDBACK = 2'b11
   } ddl_ref_t;

   // Feedback source of the phase detector
   typedef enum logic [1:0] {
      FB_PIN   = 2'b00,
      FB_INPUT = 2'b01,
      FB_TAP   = 2'b10
   } ddl_fb_t;

   // Secondary output fine phase shift
   typedef enum logic [1:0] {
      FINE_NONE = 2'b00,
      FINE_45   = 2'b01,
      FINE_22   = 2'b10,
      FINE_11   = 2'b11
   } ddl_fine_t;

   // Secondary output divider
   typedef enum logic [1:0] {
      DIV_1 = 2'b00,
      DIV_2 = 2'b01,
      DIV_4 = 2'b10
   } ddl_div_t;

   // Primary output configuration
   typedef struct packed {
      logic             bypass;
      logic             dcc_en;
      logic [TAP_W-1:0] tap;
   } ddl_pri_cfg_t;

   // Secondary output configuration
   typedef struct packed {
      logic             bypass;
      logic             dcc_en;
      logic [TAP_W-1:0] tap;
      ddl_fine_t        fine;
      ddl_div_t         div;
   } ddl_sec_cfg_t;

endpackage

// >>> logic/ddl_duty_fix.sv
// Duty-cycle corrector: rebuilds a sampled clock at 50 percent duty.
// Assumes its input is already in the system clock domain and that
// half_i holds half the measured period in system clock cycles.
`timescale 1ns/10ps
module ddl_duty_fix #(
   parameter int CNT_W = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rstn_i,
   input  wire logic             sig_i,
   input  wire logic [CNT_W-1:0] half_i,
   output logic                  dcc_o
);

   logic             sig_prev;
   logic [CNT_W-1:0] left;
   wire              rise = sig_i & ~sig_prev;

   ////////////////////////////////////////////////////////////////////
   // Rising edge restarts a high phase of half a period
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         sig_prev <= 1'b0;
         left     <= '0;
         dcc_o    <= 1'b0;
      end else begin
         sig_prev <= sig_i;
         if (half_i == '0) begin
            dcc_o <= sig_i;         // No period known yet: pass through
            left  <= '0;
         end else if (rise) begin
            dcc_o <= 1'b1;
            left  <= half_i - 1'b1;
         end else if (left != '0) begin
            left  <= left - 1'b1;
         end else begin
            dcc_o <= 1'b0;
         end
      end
   end

endmodule

// >>> tb/ddl_top_monitor.sv
// Port checker for the delay-locked loop top.
// Assumes a bind onto ddl_top and pin clocks far slower than CLK_I.
`timescale 1ns/10ps
module ddl_top_chk #(
   parameter int TAPS = ddl_pkg::DEF_TAPS
) (
   input wire logic                            CLK_I,
   input wire logic                            RSTN_I,
   input wire logic                            INPUT_CLOCK_I,
   input wire ddl_pkg::ddl_pri_cfg_t           PRIMARY_CFG_I,
   input wire ddl_pkg::ddl_sec_cfg_t           SECONDARY_CFG_I,
   input wire logic                            CODE_FREEZE_I,
   input wire logic                            CODE_UPDATE_LATCH_I,
   input wire logic                            PRIMARY_CLOCK_OUT_O,
   input wire logic                            SECONDARY_CLOCK_OUT_O,
   input wire logic [ddl_pkg::TAP_W-1:0]       DELAY_CODE_BUS_O,
   input wire logic [ddl_pkg::TAP_W-1:0]       HELD_CODE_O,
   input wire logic signed [ddl_pkg::ERR_W-1:0] PHASE_ERROR_O,
   input wire logic                            LOCK_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);
   ////////////////////////////////////////////////////////////////////////
   // Pin history; age lets the reset-cleared chain refill first
   logic [39:0] hist;
   logic [5:0]  age;
   always_ff @(posedge CLK_I) begin
      hist <= {hist[38:0], INPUT_CLOCK_I};
      age  <= !RSTN_I ? 6'h00 : age + {5'h00, age != 6'h3F};
   end
   // Plain outputs: no duty fix, no fine shift, no divider
   wire logic pri_plain = !PRIMARY_CFG_I.dcc_en && PRIMARY_CFG_I.tap < TAPS;
   wire logic sec_plain = !SECONDARY_CFG_I.bypass && !SECONDARY_CFG_I.dcc_en
      && SECONDARY_CFG_I.fine == ddl_pkg::FINE_NONE
      && SECONDARY_CFG_I.div == ddl_pkg::DIV_1 && SECONDARY_CFG_I.tap < TAPS;
   ////////////////////////////////////////////////////////////////////////
   a_reset_values: assert property ($rose(RSTN_I) |-> !LOCK_O
      && DELAY_CODE_BUS_O == ddl_pkg::CODE_RST
      && HELD_CODE_O == ddl_pkg::CODE_RST) else $error("bad reset state");
   a_freeze_holds: assert property ($changed(DELAY_CODE_BUS_O)
      |-> !$past(CODE_FREEZE_I, 2)) else $error("code moved while frozen");
   a_code_step_dir: assert property ($changed(DELAY_CODE_BUS_O) |->
      (DELAY_CODE_BUS_O == $past(DELAY_CODE_BUS_O) - 5'h01
       && $past(PHASE_ERROR_O) > 9'sh001)
      || (DELAY_CODE_BUS_O == $past(DELAY_CODE_BUS_O) + 5'h01
       && $past(PHASE_ERROR_O) < -9'sh001)) else $error("bad code step");
   a_held_latch: assert property (CODE_UPDATE_LATCH_I |=>
      HELD_CODE_O == $past(DELAY_CODE_BUS_O)) else $error("latch missed");
   a_held_stays: assert property (!CODE_UPDATE_LATCH_I |=>
      $stable(HELD_CODE_O)) else $error("held code moved");
   a_lock_window: assert property (LOCK_O |->
      PHASE_ERROR_O >= -9'sh001 && PHASE_ERROR_O <= 9'sh001)
      else $error("lock with large error");
   a_pri_bypass: assert property (age > 6'h28
      && $stable(PRIMARY_CFG_I) && pri_plain && PRIMARY_CFG_I.bypass
      |-> PRIMARY_CLOCK_OUT_O == hist[2])
      else $error("primary bypass wrong");
   a_pri_tap: assert property (age > 6'h28 && $stable(PRIMARY_CFG_I)
      && pri_plain && !PRIMARY_CFG_I.bypass |->
      PRIMARY_CLOCK_OUT_O == hist[PRIMARY_CFG_I.tap + 6'h03])
      else $error("primary tap wrong");
   a_sec_tap: assert property (age > 6'h28
      && $stable(SECONDARY_CFG_I) && sec_plain
      |-> SECONDARY_CLOCK_OUT_O == hist[SECONDARY_CFG_I.tap + 6'h03])
      else $error("secondary tap wrong");
   // Main scenarios reached
   c_lock: cover property ($rose(LOCK_O));
   c_step: cover property ($changed(DELAY_CODE_BUS_O));
   c_latch: cover property (CODE_UPDATE_LATCH_I);
endmodule

bind ddl_top ddl_top_chk #(.TAPS(TAPS)) i_chk (
   .CLK_I                 (CLK_I),
   .RSTN_I                (RSTN_I),
   .INPUT_CLOCK_I         (INPUT_CLOCK_I),
   .PRIMARY_CFG_I         (PRIMARY_CFG_I),
   .SECONDARY_CFG_I       (SECONDARY_CFG_I),
   .CODE_FREEZE_I         (CODE_FREEZE_I),
   .CODE_UPDATE_LATCH_I   (CODE_UPDATE_LATCH_I),
   .PRIMARY_CLOCK_OUT_O   (PRIMARY_CLOCK_OUT_O),
   .SECONDARY_CLOCK_OUT_O (SECONDARY_CLOCK_OUT_O),
   .DELAY_CODE_BUS_O      (DELAY_CODE_BUS_O),
   .HELD_CODE_O           (HELD_CODE_O),
   .PHASE_ERROR_O         (PHASE_ERROR_O),
   .LOCK_O                (LOCK_O)
);

// >>> tb/ddl_fabric_model.sv
// Fabric clock source and slave delay element model.
// Assumes code_i is the delay code bus of the loop under test.
`timescale 1ns/10ps
module ddl_fabric_model #(
   parameter int PERIOD = 16
) (
   input  wire logic                      clk_i,
   input  wire logic [ddl_pkg::TAP_W-1:0] code_i,
   output logic                           in_clk_o = 1'b0,
   output logic                           fb_clk_o
);
   int          phase = 0;
   logic [39:0] hist  = '0;
   // Source clock and delay line move on the falling edge
   always @(negedge clk_i) begin
      phase    <= (phase + 1) % PERIOD;
      in_clk_o <= (phase < PERIOD / 2);
      hist     <= {hist[38:0], in_clk_o};
   end
   // Delay follows the code, so code 13 aligns a 16-cycle period
   assign fb_clk_o = hist[code_i + 6'h02];
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the delay-locked loop top.
// Assumes the fabric model makes both pin clocks from the bench clock.
`timescale 1ns/10ps
module testbench;
   typedef struct {string what; int sel; logic [7:0] exp;} ddl_note_t;
   localparam logic [1:0] FINE_T [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
   localparam logic [1:0] DIV_T [6]  = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h0};
   localparam logic       DCC_T [6]  = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
   localparam logic [7:0] EXP_T [6]  = '{8'h08, 8'h08, 8'h04,
                                         8'h02, 8'h04, 8'h08};
   logic                      clk, rstn, freeze, latch, in_clk, fb_clk;
   logic                      pri_out, sec_out, lock;
   logic [ddl_pkg::TAP_W-1:0] code_bus, held;
   logic signed [8:0]         perr;
   ddl_pkg::ddl_mode_t        mode;
   ddl_pkg::ddl_ref_t         ref_sel;
   ddl_pkg::ddl_fb_t          fb_sel;
   ddl_pkg::ddl_pri_cfg_t     pri_cfg;
   ddl_pkg::ddl_sec_cfg_t     sec_cfg;
   ddl_note_t                 notes[$];
   ddl_note_t                 nt;
   int                        failures, n_checks, pri_n, sec_n, i;
   ddl_top #(.TAPS(ddl_pkg::DEF_TAPS)) i_dut (.CLK_I(clk), .RSTN_I(rstn),
      .INPUT_CLOCK_I(in_clk), .FEEDBACK_CLOCK_IN_I(fb_clk), .MODE_I(mode),
      .REF_SEL_I(ref_sel), .FB_SEL_I(fb_sel), .PRIMARY_CFG_I(pri_cfg),
      .SECONDARY_CFG_I(sec_cfg), .CODE_FREEZE_I(freeze),
      .CODE_UPDATE_LATCH_I(latch), .PRIMARY_CLOCK_OUT_O(pri_out),
      .SECONDARY_CLOCK_OUT_O(sec_out), .DELAY_CODE_BUS_O(code_bus),
      .HELD_CODE_O(held), .PHASE_ERROR_O(perr), .LOCK_O(lock));
   ddl_fabric_model #(.PERIOD(16)) i_model (.clk_i(clk), .code_i(code_bus),
      .in_clk_o(in_clk), .fb_clk_o(fb_clk));
   ////////////////////////////////////////////////////////////////////////
   // Clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Output picked by a note
   function automatic logic [7:0] seen_of(int sel);
      case (sel)
         0: return {3'h0, code_bus};
         1: return {3'h0, held};
         2: return {7'h00, lock};
         3: return pri_n[7:0];
         4: return sec_n[7:0];
         default: return perr[7:0];
      endcase
   endfunction
   task check(string what, logic [7:0] seen, logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task note(string what, int sel, logic [7:0] exp);
      notes.push_back('{what, sel, exp});
   endtask
   // Watcher: every queued note, oldest first, against the settled output
   always @(negedge clk) begin
      while (notes.size() > 0) begin
         nt = notes.pop_front();
         check(nt.what, seen_of(nt.sel), nt.exp);
      end
   end
   task tally_and_finish();
      repeat (2) @(negedge clk);
      if (failures == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Bounded wait; a hang counts as a mismatch
   task wait_lock(logic lvl);
      for (int k = 0; k < 3000 && lock !== lvl; k++) @(negedge clk);
      if (lock !== lvl) begin
         failures++;
         tally_and_finish();
      end
   endtask
   // Rising edges of both outputs over eight source periods
   task count_rises();
      logic p, s;
      pri_n = 0;
      sec_n = 0;
      for (int k = 0; k < 128; k++) begin
         p = pri_out;
         s = sec_out;
         @(negedge clk);
         pri_n += int'(pri_out & ~p);
         sec_n += int'(sec_out & ~s);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence, inputs moved on the falling edge
   initial begin
      void'($urandom(32'hC798));
      rstn = 1'b0;
      freeze = 1'b0;
      latch = 1'b0;
      mode = ddl_pkg::MODE_CUSTOM;
      ref_sel = ddl_pkg::REF_INPUT;
      fb_sel = ddl_pkg::FB_INPUT;
      pri_cfg = '0;
      sec_cfg = '0;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      note("lock", 2, 8'h00);
      wait_lock(1'b1);
      note("code_bus", 0, 8'h10);
      // Injection removal, code frozen: lock must drop
      freeze = 1'b1;
      mode = ddl_pkg::MODE_INJECT;
      wait_lock(1'b0);
      repeat (64) @(negedge clk);
      note("code_bus", 0, 8'h10);
      note("perr", 5, 8'h03);
      freeze = 1'b0;
      wait_lock(1'b1);
      note("code_bus", 0, 8'h0E);
      repeat (1 + $urandom_range(40)) @(negedge clk);
      latch = 1'b1;
      @(negedge clk);
      latch = 1'b0;
      @(negedge clk);
      note("held", 1, 8'h0E);
      // Custom sources and the time-reference preset, code frozen
      freeze = 1'b1;
      mode = ddl_pkg::MODE_CUSTOM;
      ref_sel = ddl_pkg::REF_INDIV;
      wait_lock(1'b0);
      ref_sel = ddl_pkg::REF_FEEDBACK;
      fb_sel = ddl_pkg::FB_PIN;
      wait_lock(1'b1);
      ref_sel = ddl_pkg::REF_TAP;
      fb_sel = ddl_pkg::FB_TAP;
      repeat (48) @(negedge clk);
      wait_lock(1'b1);
      note("perr", 5, 8'h00);
      // Time reference: chain tap one cycle early, error is minus one
      mode = ddl_pkg::MODE_TIMEREF;
      repeat (48) @(negedge clk);
      wait_lock(1'b1);
      note("perr", 5, 8'hFF);
      mode = ddl_pkg::MODE_INJECT;
      repeat (48) @(negedge clk);
      wait_lock(1'b1);
      note("code_bus", 0, 8'h0E);
      freeze = 1'b0;
      // Output selections; divider and shift modes from a table
      for (i = 0; i < 6; i++) begin
         pri_cfg.bypass = 1'($urandom_range(1));
         pri_cfg.tap = 5'($urandom_range(31));
         pri_cfg.dcc_en = DCC_T[i];
         sec_cfg.tap = 5'($urandom_range(31));
         sec_cfg.fine = ddl_pkg::ddl_fine_t'(FINE_T[i]);
         sec_cfg.div = ddl_pkg::ddl_div_t'(DIV_T[i]);
         sec_cfg.dcc_en = DCC_T[i];
         repeat (48) @(negedge clk);
         count_rises();
         note("pri_rises", 3, 8'h08);
         note("sec_rises", 4, EXP_T[i]);
      end
      tally_and_finish();
   end
endmodule
